// >>> genset_defs.vh
// Constants for the generator set fault supervisor.
`ifndef GENSET_DEFS_VH
`define GENSET_DEFS_VH
// Selector positions.
`define SEL_OFF 2'h0
`define SEL_MAN 2'h1
`define SEL_AUTO 2'h2
// Fault codes shown on the display.
`define CODE_NONE 12'h000
`define CODE_OVR_ACTIVE 12'h46B
`define CODE_FAIL_SHUT 12'h588
`define CODE_SHUT_AFTER_OVR 12'h463
`define CODE_OVERSPEED 12'h0EA
`define CODE_LOCAL_ESTOP 12'h599
`define CODE_REMOTE_ESTOP 12'h59A
`define CODE_POS_SENSOR 12'h0EC
`define CODE_EXCITATION 12'h91F
`define CODE_DATALINK 12'h30D
`define CODE_ENG_BUS_SHUT 12'h4DD
// Critical fault vector bit positions.
`define CRIT_OVERSPEED 0
`define CRIT_LOCAL_ESTOP 1
`define CRIT_REMOTE_ESTOP 2
`define CRIT_POS_SENSOR 3
`define CRIT_EXCITATION 4
`define CRIT_DATALINK 5
`define CRIT_ENG_BUS 6
`define CRIT_COUNT 7
// Timing.
`define CLK_PERIOD_NS 5
`define LAMP_TIMEOUT_MIN 10
`define LAMP_TIMEOUT_CYC 40'h1BF08EB000
`define FLASH_HALF_CYC 100000000
`define HOLD_CYC 200000000
`define STEP_CYC 50000000
// Indicator colours.
`define COLOR_GREEN 2'h0
`define COLOR_YELLOW 2'h1
`define COLOR_RED 2'h2
`endif

// >>> lamp_flasher.v
// Square-wave generator for the not-in-auto lamp.
`timescale 1ns/1ps
`default_nettype none
module lamp_flasher #(
  parameter [31:0] HALF_CYC = 32'd100000000
) (
  input wire clock_in,
  input wire reset_in,
  input wire enable_in,
  output reg flash_out
);
  reg [31:0] count_ff;

  // Half-period counter, held at zero while disabled; output toggles each wrap while enabled.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      count_ff <= 32'h0;
      flash_out <= 1'b0;
    end else if (!enable_in) begin
      count_ff <= 32'h0;
      flash_out <= 1'b0;
    end else if (count_ff >= HALF_CYC - 32'd1) begin
      count_ff <= 32'h0;
      flash_out <= ~flash_out;
    end else begin
      count_ff <= count_ff + 32'd1;
    end
  end
endmodule // lamp_flasher
`default_nettype wire

// >>> panel_lamp_ctrl.v
// Panel lamp button handler: short press toggles, hold runs lamp test.
`timescale 1ns/1ps
`default_nettype none
module panel_lamp_ctrl #(
  parameter [39:0] TIMEOUT_CYC = 40'd120000000000,
  parameter [31:0] HOLD_CYC = 32'd200000000,
  parameter [31:0] STEP_CYC = 32'd50000000
) (
  input wire clock_in,
  input wire reset_in,
  input wire button_in,
  output reg lamps_on_out,
  output reg test_out,
  output reg [3:0] bar_out
);
  reg btn_ff;
  reg [31:0] hold_ff;
  reg [39:0] timer_ff;
  reg [31:0] step_ff;

  // Press timing, toggle on short release, automatic lamp switch-off.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      btn_ff <= 1'b0;
      hold_ff <= 32'h0;
      timer_ff <= 40'h0;
      step_ff <= 32'h0;
      lamps_on_out <= 1'b0;
      test_out <= 1'b0;
      bar_out <= 4'h0;
    end else begin
      btn_ff <= button_in;
      if (button_in) begin
        if (hold_ff < HOLD_CYC) begin
          hold_ff <= hold_ff + 32'd1;
        end else begin
          test_out <= 1'b1; // R16
        end
      end else begin
        hold_ff <= 32'h0;
        test_out <= 1'b0;
        bar_out <= 4'h0;
      end
      // Release before the hold threshold counts as a short press.
      if (btn_ff && !button_in && hold_ff < HOLD_CYC) begin
        lamps_on_out <= ~lamps_on_out; // R16
        timer_ff <= 40'h0;
      end else if (lamps_on_out) begin
        if (timer_ff >= TIMEOUT_CYC - 40'd1) begin
          lamps_on_out <= 1'b0; // R16
          timer_ff <= 40'h0;
        end else begin
          timer_ff <= timer_ff + 40'd1;
        end
      end
      // Meters advance one bar at a time during the test.
      if (test_out) begin
        if (step_ff >= STEP_CYC - 32'd1) begin
          step_ff <= 32'h0;
          bar_out <= bar_out + 4'h1; // R16
        end else begin
          step_ff <= step_ff + 32'd1;
        end
      end else begin
        step_ff <= 32'h0;
      end
    end
  end
endmodule // panel_lamp_ctrl
`default_nettype wire

// >>> genset_fault_supervisor.v
// Generator set fault supervisor: modes, faults, override and lamps.
//
// Overview of operation
// R1: Override enabled lights warning, shows 1131.
// R2: Overridden shutdown announced, set runs, shows 1416.
// R3: Acknowledge clears message; history stays active.
// R4: Critical faults suspend override, shut down.
// R5: Override switch off after override: shut, 1123.
// R6: Override needs config enable and assigned input.
// R7: Emergency stop shuts down, blocks all starts.
// R8: Estop clears only by ordered panel sequence.
// R9: Running lamp follows generator running.
// R10: Remote-start lamp follows remote start input.
// R11: Not-in-auto lamp flashes outside auto.
// R12: Shutdown lights lamp, inhibits start; ack in off.
// R13: Warning lamp; ack or remote reset clears.
// R14: Sticky warnings clear only after shutdown.
// R15: Warning ack any position; shutdown ack off.
// R16: Lamp button toggles, times out, hold tests.
// R17: Manual run/stop acts only in manual.
// R18: Auto follows remote start; button ignored.
// R19: Off blocks starts, stops set immediately.
// R20: Menu buttons act only when symbol shown.
// R21: Indicators have source, colour, enable.
// R22: Remote reset clears faults except estop.
// R23: Flash period is a parameter.
`timescale 1ns/1ps
`include "genset_defs.vh"
`default_nettype none
module genset_fault_supervisor #(
  parameter [31:0] FLASH_HALF_CYC = `FLASH_HALF_CYC,
  parameter [39:0] LAMP_TIMEOUT_CYC = `LAMP_TIMEOUT_CYC,
  parameter [31:0] HOLD_CYC = `HOLD_CYC,
  parameter [31:0] STEP_CYC = `STEP_CYC
) (
  input wire clock_in,
  input wire reset_in,
  input wire [1:0] selector_in,
  input wire estop_pressed_in,
  input wire remote_estop_in,
  input wire ack_button_in,
  input wire run_stop_button_in,
  input wire lamp_button_in,
  input wire [3:0] menu_button_in,
  input wire [3:0] menu_symbol_shown_in,
  input wire remote_start_in,
  input wire remote_reset_in,
  input wire [3:0] customer_input_in,
  input wire override_cfg_enable_in,
  input wire [1:0] override_input_sel_in,
  input wire [6:0] critical_fault_in,
  input wire overridable_fault_in,
  input wire warning_fault_in,
  input wire sticky_warning_fault_in,
  input wire engine_running_in,
  input wire [2:0] indicator_src_sel_in,
  input wire [1:0] indicator_color_in,
  input wire indicator_enable_in,
  output reg run_cmd_out,
  output reg shutdown_out,
  output reg running_lamp_out,
  output reg remote_start_lamp_out,
  output reg not_auto_lamp_out,
  output reg shutdown_lamp_out,
  output reg warning_lamp_out,
  output reg [11:0] fault_code_out,
  output reg history_active_out,
  output reg [3:0] menu_press_out,
  output reg panel_lamps_out,
  output reg lamp_test_out,
  output reg [3:0] meter_bar_out,
  output reg [2:0] indicator_rgb_out
);
  // Fault latch and sequence state.
  reg estop_latched_ff;
  reg [1:0] estop_step_ff;
  reg shut_latched_ff;
  reg [11:0] shut_code_ff;
  reg warn_latched_ff;
  reg sticky_latched_ff;
  reg overridden_ff;
  reg msg_cleared_ff;
  reg ovr_switch_ff;
  reg ack_prev_ff;
  reg rs_prev_ff;
  reg rr_prev_ff;
  reg rr_prev2_ff;
  reg run_req_ff;
  reg [11:0] nxt_code;
  reg [6:0] src_vec;
  reg [11:0] crit_code;
  integer i;

  // Estop sequence steps after the stop latches.
  localparam [1:0] ES_WAIT_REL = 2'h0;
  localparam [1:0] ES_WAIT_OFF = 2'h1;
  localparam [1:0] ES_WAIT_ACK = 2'h2;
  localparam [1:0] ES_WAIT_SEL = 2'h3;

  wire in_off = (selector_in == `SEL_OFF);
  wire in_man = (selector_in == `SEL_MAN);
  wire in_auto = (selector_in == `SEL_AUTO);
  wire ovr_switch = customer_input_in[override_input_sel_in];
  wire ovr_en = override_cfg_enable_in && ovr_switch; // R6
  wire estop_now = estop_pressed_in | remote_estop_in;
  wire crit_now = |critical_fault_in;
  wire ack_pulse = ack_button_in && !ack_prev_ff;
  wire rs_pulse = run_stop_button_in && !rs_prev_ff;
  // Remote reset counts on release, i.e. after a full grounding cycle.
  wire rr_cycle = rr_prev2_ff && !rr_prev_ff;
  wire remote_clear = in_auto && !remote_start_in && rr_cycle; // R22
  wire ovr_off_shut = ovr_switch_ff && !ovr_switch && overridden_ff; // R5
  wire block_start = estop_latched_ff || shut_latched_ff || in_off || crit_now; // R7 R12 R19

  // Code of the first active critical fault, lowest bit first.
  always @* begin
    crit_code = `CODE_NONE;
    for (i = `CRIT_COUNT - 1; i >= 0; i = i - 1) begin
      if (critical_fault_in[i]) begin
        case (i)
          `CRIT_OVERSPEED: crit_code = `CODE_OVERSPEED;
          `CRIT_LOCAL_ESTOP: crit_code = `CODE_LOCAL_ESTOP;
          `CRIT_REMOTE_ESTOP: crit_code = `CODE_REMOTE_ESTOP;
          `CRIT_POS_SENSOR: crit_code = `CODE_POS_SENSOR;
          `CRIT_EXCITATION: crit_code = `CODE_EXCITATION;
          `CRIT_DATALINK: crit_code = `CODE_DATALINK;
          default: crit_code = `CODE_ENG_BUS_SHUT;
        endcase
      end
    end
  end

  // Edge history of panel and remote inputs.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      ack_prev_ff <= 1'b0;
      rs_prev_ff <= 1'b0;
      rr_prev_ff <= 1'b0;
      rr_prev2_ff <= 1'b0;
      ovr_switch_ff <= 1'b0;
    end else begin
      ack_prev_ff <= ack_button_in;
      rs_prev_ff <= run_stop_button_in;
      rr_prev_ff <= remote_reset_in;
      rr_prev2_ff <= rr_prev_ff;
      ovr_switch_ff <= ovr_switch;
    end
  end

  // Emergency stop latch; only the ordered panel sequence releases it.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      estop_latched_ff <= 1'b0;
      estop_step_ff <= ES_WAIT_REL;
    end else if (estop_now) begin
      estop_latched_ff <= 1'b1; // R7
      estop_step_ff <= ES_WAIT_REL;
    end else if (estop_latched_ff) begin
      case (estop_step_ff)
        ES_WAIT_REL: estop_step_ff <= ES_WAIT_OFF; // R8
        ES_WAIT_OFF: if (in_off) estop_step_ff <= ES_WAIT_ACK; // R8
        ES_WAIT_ACK: begin
          if (!in_off) begin
            estop_step_ff <= ES_WAIT_OFF;
          end else if (ack_pulse) begin
            estop_step_ff <= ES_WAIT_SEL; // R8
          end
        end
        ES_WAIT_SEL: begin
          if (!in_off) begin
            estop_latched_ff <= 1'b0; // R8
            estop_step_ff <= ES_WAIT_REL;
          end
        end
        default: estop_step_ff <= ES_WAIT_REL;
      endcase
    end
  end

  // Shutdown, warning and override latches. A new event wins over a clear.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      shut_latched_ff <= 1'b0;
      shut_code_ff <= `CODE_NONE;
      warn_latched_ff <= 1'b0;
      sticky_latched_ff <= 1'b0;
      overridden_ff <= 1'b0;
      msg_cleared_ff <= 1'b0;
    end else begin
      if (crit_now) begin
        shut_latched_ff <= 1'b1; // R4
        shut_code_ff <= crit_code; // R4
      end else if (ovr_off_shut) begin
        shut_latched_ff <= 1'b1; // R5
        shut_code_ff <= `CODE_SHUT_AFTER_OVR; // R5
      end else if (overridable_fault_in && !ovr_en) begin
        shut_latched_ff <= 1'b1; // R12
      end else if ((ack_pulse && in_off) || remote_clear) begin
        shut_latched_ff <= 1'b0; // R12 R15 R22
        shut_code_ff <= `CODE_NONE;
      end
      // Override memory lasts while the override switch stays on.
      // A fault that stays present must not bring back an acknowledged message.
      if (overridable_fault_in && ovr_en && !crit_now) begin
        overridden_ff <= 1'b1; // R2
      end else if (!ovr_switch_ff) begin
        overridden_ff <= 1'b0;
      end
      if (ack_pulse && overridden_ff) begin
        msg_cleared_ff <= 1'b1; // R3
      end else if (!ovr_en) begin
        msg_cleared_ff <= 1'b0;
      end
      if (warning_fault_in) begin
        warn_latched_ff <= 1'b1; // R13
      end else if (ack_pulse || remote_clear) begin
        warn_latched_ff <= 1'b0; // R13 R15
      end
      if (sticky_warning_fault_in) begin
        sticky_latched_ff <= 1'b1; // R14
      end else if (!engine_running_in && !run_cmd_out) begin
        sticky_latched_ff <= 1'b0; // R14
      end
    end
  end

  // Run request: manual button in manual, remote start in auto.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      run_req_ff <= 1'b0;
    end else if (block_start) begin
      run_req_ff <= 1'b0; // R19
    end else if (in_auto) begin
      run_req_ff <= remote_start_in; // R18
    end else if (in_man && rs_pulse) begin
      run_req_ff <= ~run_req_ff; // R17
    end else if (!in_man) begin
      run_req_ff <= 1'b0;
    end
  end

  // Displayed code priority: shutdown, fail to shut down, override active.
  always @* begin
    nxt_code = `CODE_NONE;
    if (shut_latched_ff && shut_code_ff != `CODE_NONE) begin
      nxt_code = shut_code_ff;
    end else if (overridden_ff && !msg_cleared_ff) begin
      nxt_code = `CODE_FAIL_SHUT; // R2
    end else if (ovr_en) begin
      nxt_code = `CODE_OVR_ACTIVE; // R1
    end
  end

  // Event sources for the configurable indicator.
  always @* begin
    src_vec = {sticky_latched_ff, warn_latched_ff, shut_latched_ff, estop_latched_ff,
      crit_now, engine_running_in, ovr_en};
  end

  // Registered outputs. Starts and stops skip time delays by design.
  always @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      run_cmd_out <= 1'b0;
      shutdown_out <= 1'b0;
      running_lamp_out <= 1'b0;
      remote_start_lamp_out <= 1'b0;
      shutdown_lamp_out <= 1'b0;
      warning_lamp_out <= 1'b0;
      fault_code_out <= `CODE_NONE;
      history_active_out <= 1'b0;
      menu_press_out <= 4'h0;
      indicator_rgb_out <= 3'h0;
    end else begin
      run_cmd_out <= run_req_ff && !block_start && !estop_now; // R7 R17 R19
      shutdown_out <= block_start || estop_now || ovr_off_shut; // R4 R5 R7 R19
      running_lamp_out <= engine_running_in; // R9
      remote_start_lamp_out <= remote_start_in; // R10
      shutdown_lamp_out <= shut_latched_ff || estop_latched_ff; // R12
      warning_lamp_out <= warn_latched_ff || sticky_latched_ff || ovr_en; // R1 R13 R14
      fault_code_out <= nxt_code;
      history_active_out <= overridden_ff; // R3
      menu_press_out <= menu_button_in & menu_symbol_shown_in; // R20
      indicator_rgb_out <= 3'h0;
      if (indicator_enable_in && indicator_src_sel_in != 3'h7 &&
          src_vec[indicator_src_sel_in]) begin
        case (indicator_color_in) // R21
          `COLOR_GREEN: indicator_rgb_out <= 3'h2;
          `COLOR_YELLOW: indicator_rgb_out <= 3'h6;
          `COLOR_RED: indicator_rgb_out <= 3'h4;
          default: indicator_rgb_out <= 3'h0;
        endcase
      end
    end
  end

  // Not-in-auto flasher with a parameterised period.
  lamp_flasher #(
    .HALF_CYC(FLASH_HALF_CYC) // R23
  ) u_flasher (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .enable_in(!in_auto), // R11
    .flash_out(not_auto_lamp_out)
  );

  // Panel lamp toggle, timeout and lamp test.
  panel_lamp_ctrl #(
    .TIMEOUT_CYC(LAMP_TIMEOUT_CYC),
    .HOLD_CYC(HOLD_CYC),
    .STEP_CYC(STEP_CYC)
  ) u_panel (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .button_in(lamp_button_in),
    .lamps_on_out(panel_lamps_out),
    .test_out(lamp_test_out),
    .bar_out(meter_bar_out)
  );
endmodule // genset_fault_supervisor
`default_nettype wire

// >>> sup_chk.sv
// Port-level checker for the generator set fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module sup_chk (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [1:0] selector_in,
  input wire logic estop_pressed_in,
  input wire logic remote_start_in,
  input wire logic engine_running_in,
  input wire logic [6:0] critical_fault_in,
  input wire logic override_cfg_enable_in,
  input wire logic [1:0] override_input_sel_in,
  input wire logic [3:0] customer_input_in,
  input wire logic [3:0] menu_button_in,
  input wire logic [3:0] menu_symbol_shown_in,
  input wire logic run_cmd_out,
  input wire logic shutdown_out,
  input wire logic running_lamp_out,
  input wire logic remote_start_lamp_out,
  input wire logic not_auto_lamp_out,
  input wire logic shutdown_lamp_out,
  input wire logic warning_lamp_out,
  input wire logic [3:0] menu_press_out
);
  // One clock domain, so clocking and reset are declared once.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  // Lamps and menu presses follow their cause one cycle later.
  chk_remote_lamp_follow: assert property ($changed(remote_start_in) |=>
    remote_start_lamp_out == $past(remote_start_in)) else $error("remote start lamp wrong");
  chk_running_lamp_follow: assert property ($changed(engine_running_in) |=>
    running_lamp_out == $past(engine_running_in)) else $error("running lamp wrong");
  chk_menu_gate: assert property ($changed(menu_button_in & menu_symbol_shown_in) |=>
    menu_press_out == $past(menu_button_in & menu_symbol_shown_in)) else $error("menu press wrong");
  // The flasher must idle in auto and keep moving in manual.
  chk_auto_quiet: assert property ((selector_in == 2'h2)[*3] |-> !not_auto_lamp_out)
    else $error("not-auto lamp lit in auto");
  chk_manual_flash: assert property ((selector_in == 2'h1)[*2] |->
    ##[1:20] ($changed(not_auto_lamp_out) || selector_in != 2'h1)) else $error("no flash");
  // Stops: the latch takes one edge, the outputs the next.
  chk_estop_stop: assert property (estop_pressed_in |-> ##2 (shutdown_lamp_out && !run_cmd_out))
    else $error("estop did not stop");
  chk_off_no_run: assert property ((selector_in == 2'h0)[*2] |-> !run_cmd_out)
    else $error("run command in off");
  chk_crit_shut: assert property ($rose(|critical_fault_in) |-> ##[1:3] shutdown_out)
    else $error("critical fault did not shut down");
  chk_override_warn: assert property (
    (override_cfg_enable_in && customer_input_in[override_input_sel_in])[*3] |-> warning_lamp_out)
    else $error("override warning lamp off");
endmodule // sup_chk

bind genset_fault_supervisor sup_chk u_sup_chk (
  .clock_in(clock_in), .reset_in(reset_in), .selector_in(selector_in),
  .estop_pressed_in(estop_pressed_in), .remote_start_in(remote_start_in),
  .engine_running_in(engine_running_in), .critical_fault_in(critical_fault_in),
  .override_cfg_enable_in(override_cfg_enable_in), .override_input_sel_in(override_input_sel_in),
  .customer_input_in(customer_input_in), .menu_button_in(menu_button_in),
  .menu_symbol_shown_in(menu_symbol_shown_in), .run_cmd_out(run_cmd_out),
  .shutdown_out(shutdown_out), .running_lamp_out(running_lamp_out),
  .remote_start_lamp_out(remote_start_lamp_out), .not_auto_lamp_out(not_auto_lamp_out),
  .shutdown_lamp_out(shutdown_lamp_out), .warning_lamp_out(warning_lamp_out),
  .menu_press_out(menu_press_out));
`default_nettype wire

// >>> panel.sv
// Operator panel and remote customer inputs facing the supervisor.
`timescale 1ns/1ps
`default_nettype none
module panel (
  input wire logic clock_in,
  output logic [1:0] selector_out,
  output logic estop_out,
  output logic remote_estop_out,
  output logic ack_out,
  output logic run_stop_out,
  output logic lamp_button_out,
  output logic remote_start_out,
  output logic remote_reset_out,
  output logic [3:0] menu_button_out,
  output logic [3:0] customer_out
);
  // Controls rest released with the selector in off.
  initial begin
    {selector_out, estop_out, remote_estop_out, ack_out, run_stop_out} = '0;
    {lamp_button_out, remote_start_out, remote_reset_out, menu_button_out, customer_out} = '0;
  end
  // Moves one control 1 ns after an edge and lets three edges pass so latches settle.
  task automatic move(input int k, input logic [3:0] v);
    @(posedge clock_in);
    #1;
    case (k)
      0: selector_out = v[1:0];
      1: estop_out = v[0];
      2: remote_estop_out = v[0];
      3: ack_out = v[0];
      4: run_stop_out = v[0];
      5: lamp_button_out = v[0];
      6: remote_start_out = v[0];
      7: remote_reset_out = v[0];
      8: menu_button_out = v;
      default: customer_out = v;
    endcase
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  // A human press spans many cycles; n adds to the four of the move itself.
  task automatic tap(input int k, input int n);
    move(k, 4'h1);
    repeat (n) @(posedge clock_in);
    move(k, 4'h0);
  endtask
endmodule // panel
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the generator set fault supervisor.
`timescale 1ns/1ps
`default_nettype none
`include "genset_defs.vh"
module tb;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic cfg_en = 1'b0, ovr = 1'b0, warn = 1'b0, sticky = 1'b0, eng = 1'b0, ind_en = 1'b0;
  logic [1:0] ovr_sel = 2'h0, color = 2'h0;
  logic [2:0] src = 3'h7;
  logic [3:0] sym = 4'h0;
  logic [6:0] crit = 7'h00;
  logic [11:0] crit_code [7] = '{`CODE_OVERSPEED, `CODE_LOCAL_ESTOP, `CODE_REMOTE_ESTOP,
    `CODE_POS_SENSOR, `CODE_EXCITATION, `CODE_DATALINK, `CODE_ENG_BUS_SHUT};
  wire [1:0] sel;
  wire estop, r_estop, ack, rs_btn, lamp_btn, rstart, rreset;
  wire run_cmd, shut, run_lamp, rs_lamp, na_lamp, sd_lamp, w_lamp, hist, pl, lt;
  wire [3:0] menu, cust, mpress, bar;
  wire [11:0] code;
  wire [2:0] rgb;
  int bad_count = 0;
  int tests_run = 0;

  // 200 MHz clock.
  always #2.5 clock_in = ~clock_in;

  // Long counts are shortened so the flash, timeout and hold fit a short run.
  genset_fault_supervisor #(.FLASH_HALF_CYC(32'h4), .LAMP_TIMEOUT_CYC(40'h28),
    .HOLD_CYC(32'h10), .STEP_CYC(32'h3)) u_genset_fault_supervisor (
    .clock_in(clock_in), .reset_in(reset_in), .selector_in(sel), .estop_pressed_in(estop),
    .remote_estop_in(r_estop), .ack_button_in(ack), .run_stop_button_in(rs_btn),
    .lamp_button_in(lamp_btn), .menu_button_in(menu), .menu_symbol_shown_in(sym),
    .remote_start_in(rstart), .remote_reset_in(rreset), .customer_input_in(cust),
    .override_cfg_enable_in(cfg_en), .override_input_sel_in(ovr_sel),
    .critical_fault_in(crit), .overridable_fault_in(ovr), .warning_fault_in(warn),
    .sticky_warning_fault_in(sticky), .engine_running_in(eng), .indicator_src_sel_in(src),
    .indicator_color_in(color), .indicator_enable_in(ind_en), .run_cmd_out(run_cmd),
    .shutdown_out(shut), .running_lamp_out(run_lamp), .remote_start_lamp_out(rs_lamp),
    .not_auto_lamp_out(na_lamp), .shutdown_lamp_out(sd_lamp), .warning_lamp_out(w_lamp),
    .fault_code_out(code), .history_active_out(hist), .menu_press_out(mpress),
    .panel_lamps_out(pl), .lamp_test_out(lt), .meter_bar_out(bar), .indicator_rgb_out(rgb));

  panel u_panel (.clock_in(clock_in), .selector_out(sel), .estop_out(estop),
    .remote_estop_out(r_estop), .ack_out(ack), .run_stop_out(rs_btn),
    .lamp_button_out(lamp_btn), .remote_start_out(rstart), .remote_reset_out(rreset),
    .menu_button_out(menu), .customer_out(cust));

  // Compares with case equality so an unknown never matches.
  task automatic ck(input string what, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic flips(output int c);
    logic p;
    c = 0;
    repeat (20) begin
      p = na_lamp;
      cyc(1);
      if (na_lamp !== p) c++;
    end
  endtask
  // Ordered panel sequence: off, acknowledge, back to manual.
  task automatic clear;
    u_panel.move(0, `SEL_OFF);
    u_panel.tap(3, 2);
    u_panel.move(0, `SEL_MAN);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic t_lamps;
    int c;
    u_panel.move(6, 4'h1);
    ck("rs_lamp on", rs_lamp, 1);
    u_panel.move(6, 4'h0);
    ck("rs_lamp off", rs_lamp, 0);
    u_panel.move(0, `SEL_MAN);
    flips(c);
    ck("flash rate", c >= 4 && c <= 6, 1);
    u_panel.move(0, `SEL_AUTO);
    flips(c);
    ck("auto flips", c, 0);
    ck("auto lamp", na_lamp, 0);
    sym = 4'h5;
    u_panel.move(8, 4'hF);
    ck("menu", mpress, 4'h5);
    u_panel.move(8, 4'h0);
    src = 3'h1;
    color = `COLOR_YELLOW;
    ind_en = 1'b1;
    eng = 1'b1;
    cyc(3);
    ck("rgb", rgb, 3'h6);
    ck("run_lamp", run_lamp, 1);
    ind_en = 1'b0;
    eng = 1'b0;
    cyc(3);
    ck("rgb off", rgb, 0);
    $display("test lamps done");
  endtask

  task automatic t_modes;
    u_panel.tap(4, 2);
    ck("auto button", run_cmd, 0);
    u_panel.move(6, 4'h1);
    ck("auto run", run_cmd, 1);
    u_panel.move(6, 4'h0);
    ck("auto stop", run_cmd, 0);
    u_panel.move(0, `SEL_MAN);
    u_panel.tap(4, 2);
    ck("manual run", run_cmd, 1);
    u_panel.move(0, `SEL_OFF);
    ck("off stop", run_cmd, 0);
    u_panel.tap(4, 2);
    ck("off block", run_cmd, 0);
    $display("test modes done");
  endtask

  // Local (k=1) or remote (k=2) stop, then the ordered release.
  task automatic t_estop(input int k);
    u_panel.move(0, `SEL_MAN);
    u_panel.tap(4, 2);
    u_panel.move(k, 4'h1);
    ck("estop lamp", sd_lamp, 1);
    ck("estop run", run_cmd, 0);
    u_panel.move(k, 4'h0);
    u_panel.tap(4, 2);
    ck("local start", run_cmd, 0);
    u_panel.move(0, `SEL_AUTO);
    u_panel.move(6, 4'h1);
    ck("remote start", run_cmd, 0);
    u_panel.move(6, 4'h0);
    u_panel.tap(7, 2);
    ck("remote reset", sd_lamp, 1);
    u_panel.tap(3, 2);
    ck("ack in auto", sd_lamp, 1);
    clear();
    ck("released", sd_lamp, 0);
    $display("test estop done");
  endtask

  task automatic t_override;
    ovr_sel = 2'h2;
    u_panel.move(9, 4'h4);
    ck("no cfg", w_lamp, 0);
    cfg_en = 1'b1;
    cyc(3);
    ck("ovr lamp", w_lamp, 1);
    ck("ovr code", code, `CODE_OVR_ACTIVE);
    u_panel.tap(4, 2);
    ovr = 1'b1;
    cyc(3);
    ck("fail code", code, `CODE_FAIL_SHUT);
    ck("no shut", shut, 0);
    ck("kept run", run_cmd, 1);
    u_panel.tap(3, 2);
    ck("ack msg", code, `CODE_OVR_ACTIVE);
    ck("history", hist, 1);
    ovr = 1'b0;
    u_panel.move(9, 4'h0);
    ck("switch off", shut, 1);
    ck("after code", code, `CODE_SHUT_AFTER_OVR);
    cfg_en = 1'b0;
    clear();
    $display("test override done");
  endtask

  task automatic t_critical;
    cfg_en = 1'b1;
    ovr_sel = 2'h0;
    u_panel.move(9, 4'h1);
    for (int i = 0; i < 7; i++) begin
      u_panel.tap(4, 2);
      crit = 7'h01 << i;
      cyc(3);
      ck("crit shut", shut, 1);
      ck("crit code", code, crit_code[i]);
      crit = 7'h00;
      clear();
    end
    cfg_en = 1'b0;
    u_panel.move(9, 4'h0);
    ck("shut cleared", shut, 0);
    $display("test critical done");
  endtask

  task automatic t_faults;
    warn = 1'b1;
    cyc(3);
    ck("warn", w_lamp, 1);
    warn = 1'b0;
    cyc(3);
    ck("warn held", w_lamp, 1);
    u_panel.tap(3, 2);
    ck("warn ack", w_lamp, 0);
    u_panel.move(0, `SEL_AUTO);
    warn = 1'b1;
    cyc(3);
    warn = 1'b0;
    u_panel.tap(7, 2);
    cyc(3);
    ck("warn rreset", w_lamp, 0);
    u_panel.move(0, `SEL_MAN);
    u_panel.tap(4, 2);
    eng = 1'b1;
    sticky = 1'b1;
    cyc(3);
    sticky = 1'b0;
    u_panel.tap(3, 2);
    ck("sticky", w_lamp, 1);
    u_panel.tap(4, 2);
    eng = 1'b0;
    cyc(3);
    ck("sticky clr", w_lamp, 0);
    ovr = 1'b1;
    cyc(3);
    ck("sd lamp", sd_lamp, 1);
    ovr = 1'b0;
    u_panel.tap(4, 2);
    ck("sd block", run_cmd, 0);
    u_panel.tap(3, 2);
    ck("sd ack man", sd_lamp, 1);
    clear();
    ck("sd clr", sd_lamp, 0);
    $display("test faults done");
  endtask

  task automatic t_panel;
    u_panel.tap(5, 1);
    ck("panel on", pl, 1);
    cyc(50);
    ck("panel timeout", pl, 0);
    u_panel.tap(5, 1);
    u_panel.tap(5, 1);
    ck("panel toggle", pl, 0);
    u_panel.move(5, 4'h1);
    cyc(20);
    ck("lamp test", lt, 1);
    ck("bar moves", bar != 4'h0, 1);
    u_panel.move(5, 4'h0);
    ck("test end", lt, 0);
    $display("test panel done");
  endtask

  // Reset for six cycles, then every scenario in turn.
  initial begin
    cyc(6);
    reset_in = 1'b0;
    cyc(2);
    t_lamps();
    t_modes();
    t_estop(1);
    t_estop(2);
    t_override();
    t_critical();
    t_faults();
    t_panel();
    test_done();
  end
  // The run needs about 800 cycles; sixteen microseconds of slack stops a hang.
  initial begin
    #20000;
    bad_count++;
    $display("[ERR] watchdog expired");
    test_done();
  end
endmodule // tb
`default_nettype wire
